// ---- design/tfsd_decoder.sv ----
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tfsd_decoder (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Instruction stream from fetch
	input  wire logic        i_instr_valid,
	input  wire logic [9:0]  i_opcode,
	// Request pulses from the timers
	input  wire logic        i_timer3_set,
	input  wire logic        i_timer4_set,
	input  wire logic        i_timer5_set,
	// Power state and detector pin
	input  wire logic        i_power_down,
	input  wire logic        i_detector_enable_pin,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output var  logic        o_pready,
	output var  logic [31:0] o_prdata,
	output var  logic        o_pslverr,
	// Results toward the core
	output var  logic        o_skip,
	output var  logic        o_squash,
	output var  logic        o_done,
	output var  logic        o_timer3_request_flag,
	output var  logic        o_timer4_request_flag,
	output var  logic        o_timer5_request_flag,
	output var  logic        o_detector_flag,
	output var  logic        o_detector_active
);

	// Register state
	logic [3:0]  ctrl_two_ff;
	logic        skip_ff;
	logic        squash_ff;
	logic        done_ff;
	logic        det_flag_ff;
	logic        det_act_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;

	logic        pin_sync;
	logic        t3_flag;
	logic        t4_flag;
	logic        t5_flag;

	tfsd_pkg::tfsd_op_e op;

	// Detector pin into the clock domain
	tfsd_sync u_pin_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async (i_detector_enable_pin),
		.o_sync  (pin_sync)
	);

	// Instruction executes unless it is the one being skipped
	wire exec = i_instr_valid & ~skip_ff;

	// Opcode decode
	wire is_t3  = exec & (i_opcode == tfsd_pkg::OPC_SKIP_T3);
	wire is_t4  = exec & (i_opcode == tfsd_pkg::OPC_SKIP_T4);
	wire is_t5  = exec & (i_opcode == tfsd_pkg::OPC_SKIP_T5);
	wire is_det = exec & (i_opcode == tfsd_pkg::OPC_SET_DETECT);

	always_comb
	begin
		op = tfsd_pkg::OP_NONE;
		if (is_t3)
			op = tfsd_pkg::OP_T3;
		else if (is_t4)
			op = tfsd_pkg::OP_T4;
		else if (is_t5)
			op = tfsd_pkg::OP_T5;
		else if (is_det)
			op = tfsd_pkg::OP_DET;
	end

	// Enable bits of the second interrupt control register
	wire en3 = ctrl_two_ff[tfsd_pkg::T3_EN_BIT];
	wire en4 = ctrl_two_ff[tfsd_pkg::T4_EN_BIT];
	wire en5 = ctrl_two_ff[tfsd_pkg::T5_EN_BIT];

	// Skip decision per operation; enable set means no-operation
	logic take_skip;
	logic clr3;
	logic clr4;
	logic clr5;
	always_comb
	begin
		take_skip = 1'b0;
		clr3      = 1'b0;
		clr4      = 1'b0;
		clr5      = 1'b0;
		case (op)
			tfsd_pkg::OP_T3:
			begin
				take_skip = ~en3 & t3_flag;
				clr3      = ~en3 & t3_flag;
			end
			tfsd_pkg::OP_T4:
			begin
				take_skip = ~en4 & t4_flag;
				clr4      = ~en4 & t4_flag;
			end
			tfsd_pkg::OP_T5:
			begin
				take_skip = ~en5 & t5_flag;
				clr5      = ~en5 & t5_flag;
			end
			default:
			begin
				take_skip = 1'b0;
			end
		endcase
	end

	// Timer request flags
	tfsd_flag u_t3_flag (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_set  (i_timer3_set),
		.i_clr  (clr3),
		.o_flag (t3_flag)
	);

	tfsd_flag u_t4_flag (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_set  (i_timer4_set),
		.i_clr  (clr4),
		.o_flag (t4_flag)
	);

	tfsd_flag u_t5_flag (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_set  (i_timer5_set),
		.i_clr  (clr5),
		.o_flag (t5_flag)
	);

	// Skip pending until the next instruction is fetched
	wire nxt_skip   = take_skip | (skip_ff & ~i_instr_valid);
	wire nxt_squash = i_instr_valid & skip_ff;
	wire nxt_done   = op != tfsd_pkg::OP_NONE;

	// Detector enable flag stays set until reset
	wire nxt_det_flag = det_flag_ff | is_det;
	wire nxt_det_act  = pin_sync & (~i_power_down | det_flag_ff);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			skip_ff     <= 1'b0;
			squash_ff   <= 1'b0;
			done_ff     <= 1'b0;
			det_flag_ff <= 1'b0;
			det_act_ff  <= 1'b0;
		end
		else
		begin
			skip_ff     <= nxt_skip;
			squash_ff   <= nxt_squash;
			done_ff     <= nxt_done;
			det_flag_ff <= nxt_det_flag;
			det_act_ff  <= nxt_det_act;
		end
	end

	// APB decode, one wait state per access
	wire access   = i_psel & i_penable;
	wire finish   = access & pready_ff;
	wire hit_ctrl = i_paddr == tfsd_pkg::ADDR_CTRL_TWO;
	wire hit_stat = i_paddr == tfsd_pkg::ADDR_STATUS;
	wire unmapped = ~hit_ctrl & ~hit_stat;
	wire wr_ctrl  = finish & i_pwrite & hit_ctrl & i_pstrb[0];
	wire bad_wr   = i_pwrite & hit_stat;

	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl)
			rd_mux[3:0] = ctrl_two_ff;
		else if (hit_stat)
		begin
			rd_mux[tfsd_pkg::ST_T3_FLAG]  = t3_flag;
			rd_mux[tfsd_pkg::ST_T4_FLAG]  = t4_flag;
			rd_mux[tfsd_pkg::ST_T5_FLAG]  = t5_flag;
			rd_mux[tfsd_pkg::ST_DET_FLAG] = det_flag_ff;
			rd_mux[tfsd_pkg::ST_DET_PIN]  = pin_sync;
			rd_mux[tfsd_pkg::ST_DET_ACT]  = det_act_ff;
			rd_mux[tfsd_pkg::ST_SKIP]     = skip_ff;
		end
	end

	wire        nxt_pready  = access & ~pready_ff;
	wire        nxt_pslverr = nxt_pready & (unmapped | bad_wr);
	wire [31:0] nxt_prdata  = (nxt_pready & ~i_pwrite) ? rd_mux : 32'h0000_0000;
	wire [3:0]  nxt_ctrl    = wr_ctrl ? i_pwdata[3:0] : ctrl_two_ff;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			pready_ff   <= 1'b0;
			pslverr_ff  <= 1'b0;
			prdata_ff   <= 32'h0000_0000;
			ctrl_two_ff <= tfsd_pkg::CTRL_TWO_RST;
		end
		else
		begin
			pready_ff   <= nxt_pready;
			pslverr_ff  <= nxt_pslverr;
			prdata_ff   <= nxt_prdata;
			ctrl_two_ff <= nxt_ctrl;
		end
	end

	// Outputs straight from flops
	assign o_pready              = pready_ff;
	assign o_pslverr             = pslverr_ff;
	assign o_prdata              = prdata_ff;
	assign o_skip                = skip_ff;
	assign o_squash              = squash_ff;
	assign o_done                = done_ff;
	assign o_timer3_request_flag = t3_flag;
	assign o_timer4_request_flag = t4_flag;
	assign o_timer5_request_flag = t5_flag;
	assign o_detector_flag       = det_flag_ff;
	assign o_detector_active     = det_act_ff;

	// Checks on the decode, skip, detector and APB behaviour
	skip_t3_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(exec && i_opcode == tfsd_pkg::OPC_SKIP_T3 && !en3 && t3_flag)
		|=> (o_skip && (!o_timer3_request_flag || $past(i_timer3_set))))
	else
		$error("Timer 3 skip or clear missing");

	nop_t3_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(exec && i_opcode == tfsd_pkg::OPC_SKIP_T3 && en3 && t3_flag)
		|=> (!o_skip && o_timer3_request_flag))
	else
		$error("Timer 3 test not a no-operation");

	skip_t4_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(exec && i_opcode == tfsd_pkg::OPC_SKIP_T4 && !en4 && t4_flag)
		|=> (o_skip && (!o_timer4_request_flag || $past(i_timer4_set))))
	else
		$error("Timer 4 skip or clear missing");

	nop_t4_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(exec && i_opcode == tfsd_pkg::OPC_SKIP_T4 && en4 && t4_flag)
		|=> (!o_skip && o_timer4_request_flag))
	else
		$error("Timer 4 test not a no-operation");

	skip_t5_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(exec && i_opcode == tfsd_pkg::OPC_SKIP_T5 && !en5 && t5_flag)
		|=> (o_skip && (!o_timer5_request_flag || $past(i_timer5_set))))
	else
		$error("Timer 5 skip or clear missing");

	nop_t5_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(exec && i_opcode == tfsd_pkg::OPC_SKIP_T5 && en5 && t5_flag)
		|=> (!o_skip && o_timer5_request_flag))
	else
		$error("Timer 5 test not a no-operation");

	no_flag_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(exec && !t3_flag && !t4_flag && !t5_flag) |=> !o_skip)
	else
		$error("Skip without a set flag");

	done_one_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(exec && (i_opcode == tfsd_pkg::OPC_SKIP_T3
			|| i_opcode == tfsd_pkg::OPC_SKIP_T4
			|| i_opcode == tfsd_pkg::OPC_SKIP_T5))
		|=> o_done)
	else
		$error("Flag test did not finish in one cycle");

	squash_next_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(o_skip && i_instr_valid)
		|=> (o_squash && !o_done && !o_skip
			&& o_detector_flag == $past(o_detector_flag)))
	else
		$error("Skipped instruction took effect");

	skip_hold_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(o_skip && !i_instr_valid) |=> o_skip)
	else
		$error("Pending skip lost before fetch");

	det_set_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(exec && i_opcode == tfsd_pkg::OPC_SET_DETECT)
		|=> (o_detector_flag && o_done) ##1 o_detector_flag)
	else
		$error("Detector enable flag not set");

	det_pin_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_detector_active |-> $past(pin_sync)
			&& (!$past(i_power_down) || $past(det_flag_ff)))
	else
		$error("Detection active without pin or enable");

	apb_wait_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(i_psel && i_penable && !o_pready) |=> o_pready)
	else
		$error("APB access not answered");

	apb_ctrl_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		wr_ctrl |=> ctrl_two_ff == $past(i_pwdata[3:0]))
	else
		$error("Control register write lost");

endmodule : tfsd_decoder
`default_nettype wire

// ---- include/tfsd_pkg.sv ----
`default_nettype none
package tfsd_pkg;

	// Opcodes of the four decoded instructions
	localparam logic [9:0] OPC_SKIP_T3    = 10'h282;
	localparam logic [9:0] OPC_SKIP_T4    = 10'h283;
	localparam logic [9:0] OPC_SKIP_T5    = 10'h284;
	localparam logic [9:0] OPC_SET_DETECT = 10'h293;

	// Fields of the second interrupt control register
	localparam int T3_EN_BIT = 0;
	localparam int T5_EN_BIT = 1;
	localparam int T4_EN_BIT = 3;
	localparam logic [3:0] CTRL_TWO_RST = 4'h0;
	localparam int CTRL_TWO_W = 4;

	// Register byte addresses on the APB
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CTRL_TWO = 12'h000;
	localparam logic [11:0] ADDR_STATUS   = 12'h004;

	// Status register fields
	localparam int ST_T3_FLAG  = 0;
	localparam int ST_T4_FLAG  = 1;
	localparam int ST_T5_FLAG  = 2;
	localparam int ST_DET_FLAG = 3;
	localparam int ST_DET_PIN  = 4;
	localparam int ST_DET_ACT  = 5;
	localparam int ST_SKIP     = 6;

	// Decoded operation
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_T3   = 3'b001,
		OP_T4   = 3'b010,
		OP_T5   = 3'b011,
		OP_DET  = 3'b100
	} tfsd_op_e;

endpackage : tfsd_pkg
`default_nettype wire

// ---- design/tfsd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two flop synchroniser for a level from a pin
module tfsd_sync (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_async,
	output var  logic o_sync
);

	logic meta_ff;
	logic sync_ff;

	// First stage feeds only the second stage
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end
		else
		begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;

endmodule : tfsd_sync
`default_nettype wire

// ---- design/tfsd_flag.sv ----
`timescale 1ns/1ps
`default_nettype none
// Sticky request flag, set wins over clear
module tfsd_flag (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_set,
	input  wire logic i_clr,
	output var  logic o_flag
);

	logic flag_ff;
	wire  nxt_flag = i_set | (flag_ff & ~i_clr);

	// Hold flag until cleared
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			flag_ff <= 1'b0;
		else
			flag_ff <= nxt_flag;
	end

	assign o_flag = flag_ff;

endmodule : tfsd_flag
`default_nettype wire

// ---- testbench/tb_timer_flag_skip_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_timer_flag_skip_decoder;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_instr_valid = 1'b0;
	logic [9:0]  i_opcode = 10'h000;
	logic [2:0]  tset = 3'h0;
	logic        i_power_down = 1'b0;
	logic        i_detector_enable_pin = 1'b0;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0;
	logic [3:0]  i_pstrb = 4'hf;
	logic        o_pready, o_pslverr, o_skip, o_squash, o_done;
	logic [31:0] o_prdata;
	logic [2:0]  flg;
	logic        o_detector_flag, o_detector_active;
	int          errors = 0;
	int          compares = 0;
	logic [9:0]  opc [3];
	int          enb [3];

	tfsd_decoder u_tfsd_decoder (
		.i_clk, .i_rst, .i_instr_valid, .i_opcode,
		.i_timer3_set(tset[0]), .i_timer4_set(tset[1]),
		.i_timer5_set(tset[2]), .i_power_down, .i_detector_enable_pin,
		.i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
		.o_pready, .o_prdata, .o_pslverr, .o_skip, .o_squash, .o_done,
		.o_timer3_request_flag(flg[0]), .o_timer4_request_flag(flg[1]),
		.o_timer5_request_flag(flg[2]), .o_detector_flag,
		.o_detector_active
	);

	// Clock, 10 ns period
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end

	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// APB transfer; read checks data, both check error response
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic e);
		int n;
		n = 0;
		i_psel   <= 1'b1;
		i_pwrite <= w;
		i_paddr  <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_pready !== 1'b1);
		chk(o_pready, 1'b1);
		chk(n, 2);
		if (!w)
			chk(o_prdata, d);
		chk(o_pslverr, e);
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clk);
	endtask : acc

	// One instruction word, then check done, skip and squash
	task automatic ins(input logic [9:0] op, input logic dn,
		input logic sk, input logic sq);
		i_instr_valid <= 1'b1;
		i_opcode      <= op;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		@(posedge i_clk);
		chk(o_done, dn);
		chk(o_skip, sk);
		chk(o_squash, sq);
	endtask : ins

	// One request pulse from a timer
	task automatic pulse(input int k);
		tset[k] <= 1'b1;
		@(posedge i_clk);
		tset <= 3'h0;
		@(posedge i_clk);
	endtask : pulse

	task automatic final_report;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	// Watchdog against a hang
	initial
	begin
		repeat (3000) @(posedge i_clk);
		errors++;
		final_report();
	end

	// Test sequence
	initial
	begin
		opc = '{tfsd_pkg::OPC_SKIP_T3, tfsd_pkg::OPC_SKIP_T4,
			tfsd_pkg::OPC_SKIP_T5};
		enb = '{tfsd_pkg::T3_EN_BIT, tfsd_pkg::T4_EN_BIT,
			tfsd_pkg::T5_EN_BIT};
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		// Reset values, refusals, strobe
		acc(1'b0, tfsd_pkg::ADDR_CTRL_TWO, 32'h0, 1'b0);
		acc(1'b0, tfsd_pkg::ADDR_STATUS, 32'h0, 1'b0);
		acc(1'b0, 12'h008, 32'h0, 1'b1);
		acc(1'b1, tfsd_pkg::ADDR_STATUS, 32'h7f, 1'b1);
		i_pstrb <= 4'he;
		acc(1'b1, tfsd_pkg::ADDR_CTRL_TWO, 32'hf, 1'b0);
		i_pstrb <= 4'hf;
		acc(1'b0, tfsd_pkg::ADDR_CTRL_TWO, 32'h0, 1'b0);
		$display("test registers done");
		// Each timer: enable set is no-op, clear skips and clears
		for (int k = 0; k < 3; k++)
		begin
			acc(1'b1, tfsd_pkg::ADDR_CTRL_TWO, 32'hf, 1'b0);
			pulse(k);
			ins(opc[k], 1'b1, 1'b0, 1'b0);
			chk(flg, 3'h1 << k);
			acc(1'b1, tfsd_pkg::ADDR_CTRL_TWO, 32'hf ^ (32'h1 << enb[k]), 1'b0);
			acc(1'b0, tfsd_pkg::ADDR_CTRL_TWO, 32'hf ^ (32'h1 << enb[k]), 1'b0);
			ins(opc[k], 1'b1, 1'b1, 1'b0);
			chk(flg, 3'h0);
			ins(tfsd_pkg::OPC_SET_DETECT, 1'b0, 1'b0, 1'b1);
			chk(o_detector_flag, 1'b0);
			ins(opc[k], 1'b1, 1'b0, 1'b0);
			$display("test timer %0d done", k + 3);
		end
		// Detector flag and pin
		i_detector_enable_pin <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk(o_detector_active, 1'b1);
		i_power_down <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk(o_detector_active, 1'b0);
		ins(tfsd_pkg::OPC_SET_DETECT, 1'b1, 1'b0, 1'b0);
		chk(o_detector_flag, 1'b1);
		repeat (4) @(posedge i_clk);
		chk(o_detector_active, 1'b1);
		acc(1'b0, tfsd_pkg::ADDR_STATUS, 32'h38, 1'b0);
		i_detector_enable_pin <= 1'b0;
		repeat (4) @(posedge i_clk);
		chk(o_detector_active, 1'b0);
		$display("test detector done");
		// Mid-run reset clears flag and register
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk(o_detector_flag, 1'b0);
		acc(1'b0, tfsd_pkg::ADDR_CTRL_TWO, 32'h0, 1'b0);
		$display("test reset done");
		final_report();
	end

endmodule : tb_timer_flag_skip_decoder
`default_nettype wire
